// ### logic/mrsc_top.v
/*
  mac reset and startup control: priority register, gated soft reset,
  module enable gating, transmit holdoff, interrupt pacing and a
  management serial engine with clock divider and preamble option.
  assumes a classic wishbone master on clk, dma idle levels and
  requests from logic on clk, link and select pins from outside.
*/
`timescale 1ns/1ps
`include "mrsc_defines.vh"

module mrsc_top
(
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire module_enable,
  input wire rx_dma_idle,
  input wire tx_dma_idle,
  input wire descriptor_error,
  input wire tx_request,
  input wire mac_event,
  input wire link_pin,
  input wire [1:0] interface_select_pins,
  output reg [1:0] media_select_ff,
  output reg [2:0] prio_first_ff,
  output reg [2:0] prio_second_ff,
  output reg mac_core_reset_ff,
  output reg host_error_interrupt_ff,
  output reg tx_start_ff,
  output wire combined_irq,
  output reg mdc_ff,
  output reg mdio_o_ff,
  output reg mdio_oe_ff
);

// ----------------------------------------
// state and declarations
// ----------------------------------------
localparam ST_IDLE = 3'b001;
localparam ST_PRE = 3'b010;
localparam ST_SHIFT = 3'b100;

reg [2:0] pdiv_ff;
reg ptick_ff;
reg srst_pend_ff;
reg [7:0] mcfg_ff;
reg md_en_ff;
reg md_pre_off_ff;
reg [15:0] md_div_ff;
reg [31:0] md_frame_ff;
reg md_go_ff;
reg comb_en_ff;
reg [7:0] pace_ff;
reg en_d_ff;
reg [1:0] sel_meta_ff;
reg [1:0] sel_sync_ff;
reg [2:0] sel_age_ff;
reg [2:0] st_ff;
reg [2:0] nxt_st;
reg [5:0] bit_ff;
reg [15:0] mdcnt_ff;
reg [31:0] shift_ff;
reg [31:0] rd_mux;
wire link_s;
wire hold_done;
wire acc;
wire wr;
wire en_rise;
wire core_clr;
wire mdc_fall;

assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wr = acc & wb_we_i & wb_sel_i[0] & module_enable;
assign en_rise = module_enable & ~en_d_ff;
assign core_clr = mac_core_reset_ff | en_rise;
assign mdc_fall = ptick_ff & mdc_ff & (mdcnt_ff == 16'h0000);

// ----------------------------------------
// peripheral clock enable, cpu clock / 6
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    pdiv_ff <= 3'h0;
    ptick_ff <= 1'b0;
  end
  else
  begin
    ptick_ff <= (pdiv_ff == `MRSC_PCLK_DIV);
    if (pdiv_ff == `MRSC_PCLK_DIV)
      pdiv_ff <= 3'h0;
    else
      pdiv_ff <= pdiv_ff + 3'h1;
  end
end

// ----------------------------------------
// wishbone slave, one-wait answer
// ----------------------------------------
always @*
begin
  rd_mux = 32'h00000000;
  case (wb_adr_i)
    `MRSC_OFS_PRIO:
    begin
      rd_mux[`MRSC_PRIO0_LO +: 3] = prio_first_ff;
      rd_mux[`MRSC_PRIO1_LO +: 3] = prio_second_ff;
    end
    `MRSC_OFS_SRST: rd_mux[0] = srst_pend_ff;
    `MRSC_OFS_MDCTL:
    begin
      rd_mux[`MRSC_MD_EN_BIT] = md_en_ff;
      rd_mux[`MRSC_MD_PRE_BIT] = md_pre_off_ff;
      rd_mux[15:0] = md_div_ff;
    end
    `MRSC_OFS_MDFRM: rd_mux = {31'h00000000, md_go_ff | ~st_ff[0]};
    `MRSC_OFS_COMB: rd_mux = {16'h0000, pace_ff, 7'h00, comb_en_ff};
    `MRSC_OFS_STAT:
      rd_mux = {26'h0000000, media_select_ff, srst_pend_ff, ~hold_done, 1'b0, host_error_interrupt_ff};
    `MRSC_OFS_MCFG: rd_mux = {24'h000000, mcfg_ff};
    default: rd_mux = 32'h00000000;
  endcase
end

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h00000000;
  end
  else
  begin
    wb_ack_o <= acc;
    if (acc && !wb_we_i)
      wb_dat_o <= module_enable ? rd_mux : 32'h00000000;
  end
end

// ----------------------------------------
// system priority register, not a mac register
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    prio_first_ff <= `MRSC_PRIO_RST;
    prio_second_ff <= `MRSC_PRIO_RST;
  end
  else if (wr && wb_adr_i == `MRSC_OFS_PRIO)
  begin
    prio_first_ff <= wb_dat_i[`MRSC_PRIO0_LO +: 3];
    if (wb_sel_i[1])
      prio_second_ff <= wb_dat_i[`MRSC_PRIO1_LO +: 3];
  end
end

// ----------------------------------------
// soft reset request, waits for idle dmas
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    srst_pend_ff <= 1'b0;
    mac_core_reset_ff <= 1'b0;
    en_d_ff <= 1'b0;
  end
  else
  begin
    en_d_ff <= module_enable;
    mac_core_reset_ff <= 1'b0;
    if (srst_pend_ff && rx_dma_idle && tx_dma_idle)
    begin
      srst_pend_ff <= 1'b0;
      mac_core_reset_ff <= 1'b1;
    end
    // a new request landing as the reset executes stays pending
    if (wr && wb_adr_i == `MRSC_OFS_SRST && wb_dat_i[0])
      srst_pend_ff <= 1'b1;
  end
end

// ----------------------------------------
// mac core configuration, cleared by core reset
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
  if (rst)
    mcfg_ff <= `MRSC_MCFG_RST;
  else if (core_clr)
    mcfg_ff <= `MRSC_MCFG_RST;
  else if (wr && wb_adr_i == `MRSC_OFS_MCFG)
    mcfg_ff <= wb_dat_i[7:0];
end

// ----------------------------------------
// sticky host error, hardware reset only
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
  if (rst)
    host_error_interrupt_ff <= 1'b0;
  else if (descriptor_error)
    host_error_interrupt_ff <= 1'b1;
end

// ----------------------------------------
// media select latched once after reset
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    sel_meta_ff <= 2'h0;
    sel_sync_ff <= 2'h0;
    sel_age_ff <= 3'h0;
    media_select_ff <= 2'h0;
  end
  else
  begin
    sel_meta_ff <= interface_select_pins;
    sel_sync_ff <= sel_meta_ff;
    sel_age_ff <= {sel_age_ff[1:0], 1'b1};
    // one-shot capture once the synchroniser holds the strap
    if (sel_age_ff[1] && !sel_age_ff[2])
      media_select_ff <= sel_sync_ff;
  end
end

// ----------------------------------------
// transmit gate behind the link holdoff
// ----------------------------------------
mrsc_holdoff u_holdoff
(
  .clk(clk),
  .rst(rst),
  .link_pin(link_pin),
  .link_ff(link_s),
  .done_ff(hold_done)
);

always @(posedge clk or posedge rst)
begin
  if (rst)
    tx_start_ff <= 1'b0;
  else
    tx_start_ff <= tx_request & hold_done & link_s & mcfg_ff[0];
end

// ----------------------------------------
// combiner control and pacing, no soft reset
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    comb_en_ff <= 1'b0;
    pace_ff <= `MRSC_PACE_RST;
  end
  else if (wr && wb_adr_i == `MRSC_OFS_COMB)
  begin
    comb_en_ff <= wb_dat_i[0];
    if (wb_sel_i[1])
      pace_ff <= wb_dat_i[15:8];
  end
end

mrsc_pace u_pace
(
  .clk(clk),
  .rst(rst),
  .tick(ptick_ff),
  .int_en(comb_en_ff),
  .event_in(mac_event),
  .pace_cnt(pace_ff),
  .irq_ff(combined_irq)
);

// ----------------------------------------
// management control, no soft reset path
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    md_en_ff <= 1'b0;
    md_pre_off_ff <= 1'b0;
    md_div_ff <= `MRSC_MD_DIV_RST;
    md_frame_ff <= 32'h00000000;
    md_go_ff <= 1'b0;
  end
  else
  begin
    if (st_ff[0] == 1'b0)
      md_go_ff <= 1'b0;
    if (wr && wb_adr_i == `MRSC_OFS_MDCTL)
    begin
      md_en_ff <= wb_dat_i[`MRSC_MD_EN_BIT];
      md_pre_off_ff <= wb_dat_i[`MRSC_MD_PRE_BIT];
      md_div_ff <= wb_dat_i[15:0];
    end
    if (wr && wb_adr_i == `MRSC_OFS_MDFRM && st_ff[0])
    begin
      md_frame_ff <= wb_dat_i;
      md_go_ff <= 1'b1;
    end
  end
end

// ----------------------------------------
// management clock from peripheral ticks
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    mdcnt_ff <= 16'h0000;
    mdc_ff <= 1'b0;
  end
  else if (!md_en_ff)
  begin
    mdcnt_ff <= 16'h0000;
    mdc_ff <= 1'b0;
  end
  else if (ptick_ff)
  begin
    if (mdcnt_ff == 16'h0000)
    begin
      mdcnt_ff <= md_div_ff;
      mdc_ff <= ~mdc_ff;
    end
    else
      mdcnt_ff <= mdcnt_ff - 16'h0001;
  end
end

// ----------------------------------------
// management frame engine
// ----------------------------------------
always @*
begin
  nxt_st = st_ff;
  case (st_ff)
    ST_IDLE:
      if (md_go_ff && md_en_ff && mdc_fall)
        nxt_st = md_pre_off_ff ? ST_SHIFT : ST_PRE;
    ST_PRE:
      if (mdc_fall && bit_ff == `MRSC_MD_PRE_LEN)
        nxt_st = ST_SHIFT;
    ST_SHIFT:
      if (mdc_fall && bit_ff == `MRSC_MD_FRM_LEN)
        nxt_st = ST_IDLE;
    default: nxt_st = ST_IDLE;
  endcase
  if (!md_en_ff)
    nxt_st = ST_IDLE;
end

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    st_ff <= ST_IDLE;
    bit_ff <= 6'h00;
    shift_ff <= 32'h00000000;
    mdio_o_ff <= 1'b0;
    mdio_oe_ff <= 1'b0;
  end
  else
  begin
    st_ff <= nxt_st;
    if (nxt_st == ST_IDLE)
    begin
      bit_ff <= 6'h00;
      mdio_oe_ff <= 1'b0;
      mdio_o_ff <= 1'b0;
    end
    else if (mdc_fall)
    begin
      mdio_oe_ff <= 1'b1;
      if (nxt_st != st_ff || st_ff[0])
      begin
        bit_ff <= 6'h00;
        if (nxt_st == ST_SHIFT)
        begin
          mdio_o_ff <= st_ff[0] ? md_frame_ff[31] : shift_ff[31];
          shift_ff <= st_ff[0] ? {md_frame_ff[30:0], 1'b0} : {shift_ff[30:0], 1'b0};
        end
        else
        begin
          mdio_o_ff <= 1'b1;
          shift_ff <= md_frame_ff;
        end
      end
      else
      begin
        bit_ff <= bit_ff + 6'h01;
        if (st_ff[2])
        begin
          mdio_o_ff <= shift_ff[31];
          shift_ff <= {shift_ff[30:0], 1'b0};
        end
        else
          mdio_o_ff <= 1'b1;
      end
    end
  end
end

endmodule // mrsc_top

// ### logic/mrsc_defines.vh
/*
  constants for the mac reset and startup control block: register
  offsets, field positions, reset values and timing counts.
  assumes inclusion by bare name from the logic/ files.
*/
`ifndef MRSC_DEFINES_VH
`define MRSC_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MRSC_OFS_PRIO 8'h00
`define MRSC_OFS_SRST 8'h04
`define MRSC_OFS_MDCTL 8'h08
`define MRSC_OFS_MDFRM 8'h0C
`define MRSC_OFS_COMB 8'h10
`define MRSC_OFS_STAT 8'h14
`define MRSC_OFS_MCFG 8'h18

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define MRSC_PRIO_RST 3'h7
`define MRSC_PRIO0_LO 0
`define MRSC_PRIO1_LO 12
`define MRSC_MD_EN_BIT 30
`define MRSC_MD_PRE_BIT 20
`define MRSC_MD_DIV_RST 16'h00FF
`define MRSC_PACE_RST 8'h04
`define MRSC_MCFG_RST 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define MRSC_PCLK_DIV 3'h5
`define MRSC_HOLD_CYC 13'h1000
`define MRSC_MD_PRE_LEN 6'h1F
`define MRSC_MD_FRM_LEN 6'h1F

`endif

// ### logic/mrsc_holdoff.v
/*
  transmit holdoff: after reset, counts transmit clock cycles once the
  link level is high and reports when transmission may begin.
  assumes the transmit clock equals clk and link_pin is asynchronous.
*/
`timescale 1ns/1ps
`include "mrsc_defines.vh"

module mrsc_holdoff
(
  input wire clk,
  input wire rst,
  input wire link_pin,
  output reg link_ff,
  output reg done_ff
);

reg link_meta_ff;
reg [12:0] cnt_ff;

// ----------------------------------------
// link synchroniser and holdoff count
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    link_meta_ff <= 1'b0;
    link_ff <= 1'b0;
    cnt_ff <= 13'h0000;
    done_ff <= 1'b0;
  end
  else
  begin
    link_meta_ff <= link_pin;
    link_ff <= link_meta_ff;
    if (!done_ff)
    begin
      if (!link_ff)
        cnt_ff <= 13'h0000;
      else if (cnt_ff == `MRSC_HOLD_CYC - 13'h0001)
        done_ff <= 1'b1;
      else
        cnt_ff <= cnt_ff + 13'h0001;
    end
  end
end

endmodule // mrsc_holdoff

// ### logic/mrsc_pace.v
/*
  interrupt pacing for the combiner: spaces output pulses by a count
  of peripheral clock ticks.
  assumes tick is a one-cycle enable at the peripheral rate.
*/
`timescale 1ns/1ps
`include "mrsc_defines.vh"

module mrsc_pace
(
  input wire clk,
  input wire rst,
  input wire tick,
  input wire int_en,
  input wire event_in,
  input wire [7:0] pace_cnt,
  output reg irq_ff
);

reg pend_ff;
reg [7:0] gap_ff;

// ----------------------------------------
// pending flag and re-trigger gap
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    pend_ff <= 1'b0;
    gap_ff <= 8'h00;
    irq_ff <= 1'b0;
  end
  else
  begin
    irq_ff <= 1'b0;
    if (!int_en)
    begin
      gap_ff <= 8'h00;
      pend_ff <= pend_ff | event_in;
    end
    else if (pend_ff && gap_ff == 8'h00)
    begin
      irq_ff <= 1'b1;
      pend_ff <= event_in;
      gap_ff <= pace_cnt;
    end
    else
    begin
      pend_ff <= pend_ff | event_in;
      if (tick && gap_ff != 8'h00)
        gap_ff <= gap_ff - 8'h01;
    end
  end
end

endmodule // mrsc_pace

// ### dv/mrsc_props.sv
/*
  checker for mrsc_top: bus answers, priority fields, soft reset,
  host error and transmit holdoff, seen at the top ports only.
  assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps

module mrsc_props
(
  input logic clk,
  input logic rst,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic module_enable,
  input logic rx_dma_idle,
  input logic tx_dma_idle,
  input logic descriptor_error,
  input logic tx_request,
  input logic link_pin,
  input logic [2:0] prio_first_ff,
  input logic [2:0] prio_second_ff,
  input logic mac_core_reset_ff,
  input logic host_error_interrupt_ff,
  input logic tx_start_ff
);
  // ----------------------------------------
  // link high time seen at the pin
  // ----------------------------------------
  logic [12:0] lnk_cnt_ff;
  logic hold_done_ff;
  logic [12:0] nxt_lnk_cnt;
  logic nxt_hold_done;
  logic wr_go;
  assign nxt_lnk_cnt = link_pin ? lnk_cnt_ff + 13'h1 : 13'h0;
  assign nxt_hold_done = hold_done_ff || (link_pin && lnk_cnt_ff == 13'hFFF);
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lnk_cnt_ff <= 13'h0;
      hold_done_ff <= 1'b0;
    end
    else
    begin
      lnk_cnt_ff <= hold_done_ff ? lnk_cnt_ff : nxt_lnk_cnt;
      hold_done_ff <= nxt_hold_done;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_prio_reset:
    assert property ($past(rst) |-> prio_first_ff == 3'h7 && prio_second_ff == 3'h7)
    else $error("priority not at reset value");
  a_prio_first:
    assert property (wr_go && module_enable && wb_adr_i == 8'h00 |=> prio_first_ff == $past(wb_dat_i[2:0]))
    else $error("first priority not written");
  a_prio_second:
    assert property (wr_go && module_enable && wb_sel_i[1] && wb_adr_i == 8'h00
      |=> prio_second_ff == $past(wb_dat_i[14:12]))
    else $error("second priority not written");
  a_off_write:
    assert property (wr_go && !module_enable |=> $stable(prio_first_ff) && $stable(prio_second_ff))
    else $error("write taken while disabled");
  a_off_read:
    assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && !module_enable
      |=> wb_ack_o && wb_dat_o == 32'h0)
    else $error("disabled read not zero");
  a_srst_go:
    assert property (wr_go && module_enable && wb_adr_i == 8'h04 && wb_dat_i[0] ##1 (rx_dma_idle && tx_dma_idle)
      |=> mac_core_reset_ff)
    else $error("soft reset not executed");
  a_srst_idle:
    assert property (mac_core_reset_ff |-> $past(rx_dma_idle) && $past(tx_dma_idle))
    else $error("soft reset while dma busy");
  a_srst_scope:
    assert property (mac_core_reset_ff && !$past(wr_go) |-> $stable(prio_first_ff) && $stable(prio_second_ff))
    else $error("soft reset touched priority");
  a_herr_sticky:
    assert property (descriptor_error || host_error_interrupt_ff |=> host_error_interrupt_ff)
    else $error("host error not held");
  a_tx_holdoff:
    assert property (tx_start_ff |-> hold_done_ff)
    else $error("transmit inside holdoff");
  a_tx_cause:
    assert property (tx_start_ff |-> $past(tx_request))
    else $error("transmit without request");
endmodule // mrsc_props

bind mrsc_top mrsc_props u_props
(
  .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .module_enable, .rx_dma_idle, .tx_dma_idle, .descriptor_error, .tx_request,
  .link_pin, .prio_first_ff, .prio_second_ff, .mac_core_reset_ff, .host_error_interrupt_ff, .tx_start_ff
);

// ### dv/mrsc_phy_model.sv
/*
  phy model: reports link and captures management frame bits.
  assumes bits are sampled on the rising management clock.
*/
`timescale 1ns/1ps

module mrsc_phy_model
(
  input wire mdc,
  input wire mdio_o,
  input wire mdio_oe,
  input wire link_cmd,
  input wire clr,
  output wire link_pin,
  output reg [7:0] bit_cnt,
  output reg [31:0] frm
);
  assign link_pin = link_cmd;
  // counts every driven bit, preamble included
  always @(posedge mdc or posedge clr)
  begin
    if (clr)
      bit_cnt <= 8'h00;
    else if (mdio_oe)
    begin
      bit_cnt <= bit_cnt + 8'h01;
      frm <= {frm[30:0], mdio_o};
    end
  end
endmodule // mrsc_phy_model

// ### dv/tb_top.sv
/*
  testbench for mrsc_top: register, soft reset, pacing,
  management frame and holdoff tests over wishbone.
  assumes the phy model and the bound checker.
*/
`timescale 1ns/1ps

module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, en = 1'b1, rx_idle = 1'b1, tx_idle = 1'b1;
  logic derr = 1'b0, tx_req = 1'b0, mev = 1'b0, link_cmd = 1'b0, clr = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd_o, mdv;
  logic ack, link, mdc, mdo, mdoe, core_rst, herr, tx_start, irq;
  logic [1:0] media;
  logic [2:0] p1, p2, evs;
  logic [7:0] bit_cnt;
  logic [31:0] frm;
  int errors = 0, cmp_count = 0, n, i;
  assign evs = {irq, tx_start, core_rst};

  always #5 clk = ~clk;

  mrsc_top u_dut
  (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack), .module_enable(en),
    .rx_dma_idle(rx_idle), .tx_dma_idle(tx_idle), .descriptor_error(derr), .tx_request(tx_req),
    .mac_event(mev), .link_pin(link), .interface_select_pins(2'h1), .media_select_ff(media),
    .prio_first_ff(p1), .prio_second_ff(p2), .mac_core_reset_ff(core_rst),
    .host_error_interrupt_ff(herr), .tx_start_ff(tx_start), .combined_irq(irq),
    .mdc_ff(mdc), .mdio_o_ff(mdo), .mdio_oe_ff(mdoe)
  );

  mrsc_phy_model u_phy
  (
    .mdc(mdc), .mdio_o(mdo), .mdio_oe(mdoe), .link_cmd(link_cmd), .clr(clr),
    .link_pin(link), .bit_cnt(bit_cnt), .frm(frm)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      errors++;
      summarize;
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask

  // waits for one of core reset, transmit start, irq
  task wt(input int b, input int lim);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (evs[b] !== 1'b1 && n < lim);
    if (evs[b] !== 1'b1)
    begin
      errors++;
      summarize;
    end
  endtask

  task ev;
    @(posedge clk);
    mev <= 1'b1;
    @(posedge clk);
    mev <= 1'b0;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'hFFFFFFFF, 32'h00007007);
    rd(8'h14, 32'h00000030, 32'h00000010);
    chk({26'h0, p2, p1}, 32'h0000003F);
    xf(1'b1, 8'h00, 32'h00005002);
    rd(8'h00, 32'hFFFFFFFF, 32'h00005002);
    xf(1'b1, 8'h00, 32'h00000000);
    chk({26'h0, p2, p1}, 32'h00000000);
    xf(1'b1, 8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'hFFFFFFFF, 32'h00007007);
    $display("test 1 done");
    xf(1'b1, 8'h00, 32'h00001001);
    xf(1'b1, 8'h18, 32'h0000005A);
    @(posedge clk);
    en <= 1'b0;
    xf(1'b1, 8'h00, 32'h00000000);
    rd(8'h00, 32'hFFFFFFFF, 32'h00000000);
    @(posedge clk);
    en <= 1'b1;
    rd(8'h00, 32'hFFFFFFFF, 32'h00001001);
    rd(8'h18, 32'hFFFFFFFF, 32'h00000000);
    rd(8'h40, 32'hFFFFFFFF, 32'h00000000);
    $display("test 2 done");
    xf(1'b1, 8'h18, 32'h00000001);
    @(posedge clk);
    derr <= 1'b1;
    tx_idle <= 1'b0;
    @(posedge clk);
    derr <= 1'b0;
    xf(1'b1, 8'h04, 32'h00000001);
    rd(8'h04, 32'hFFFFFFFF, 32'h00000001);
    rd(8'h18, 32'hFFFFFFFF, 32'h00000001);
    @(posedge clk);
    tx_idle <= 1'b1;
    wt(0, 20);
    rd(8'h04, 32'hFFFFFFFF, 32'h00000000);
    rd(8'h18, 32'hFFFFFFFF, 32'h00000000);
    rd(8'h00, 32'hFFFFFFFF, 32'h00001001);
    rd(8'h14, 32'h00000001, 32'h00000001);
    $display("test 3 done");
    for (i = 0; i < 2; i++)
    begin
      mdv = (i == 0) ? 32'h40100008 : 32'h40000008;
      xf(1'b1, 8'h08, mdv);
      rd(8'h08, 32'hFFFFFFFF, mdv);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      xf(1'b1, 8'h0C, 32'hA5C30F96);
      n = 0;
      do
      begin
        xf(1'b0, 8'h0C, 32'h0);
        n++;
      end
      while (rdat[0] !== 1'b0 && n < 3000);
      if (rdat[0] !== 1'b0)
      begin
        errors++;
        summarize;
      end
      chk(32'(bit_cnt), (i == 0) ? 32'h00000020 : 32'h00000040);
      chk(frm, 32'hA5C30F96);
    end
    $display("test 4 done");
    xf(1'b1, 8'h10, 32'h0000FF01);
    ev;
    wt(2, 20);
    ev;
    wt(2, 2000);
    chk(32'(n >= 1524 && n <= 1540), 32'h00000001);
    xf(1'b1, 8'h10, 32'h0000FF00);
    xf(1'b1, 8'h10, 32'h0000FF01);
    ev;
    wt(2, 20);
    $display("test 5 done");
    xf(1'b1, 8'h18, 32'h00000001);
    @(posedge clk);
    tx_req <= 1'b1;
    link_cmd <= 1'b1;
    wt(1, 4300);
    chk(32'(n >= 4097 && n <= 4106), 32'h00000001);
    rd(8'h14, 32'h00000004, 32'h00000000);
    $display("test 6 done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h14, 32'h00000001, 32'h00000000);
    rd(8'h00, 32'hFFFFFFFF, 32'h00007007);
    rd(8'h10, 32'h0000FF01, 32'h00000400);
    rd(8'h08, 32'hFFFFFFFF, 32'h000000FF);
    xf(1'b1, 8'h18, 32'h00000001);
    rd(8'h14, 32'h00000004, 32'h00000004);
    chk(32'(tx_start), 32'h00000000);
    $display("test 7 done");
    summarize;
  end
endmodule // tb_top
